//--- logic/crhs_pkg.sv
`default_nettype none
package crhs_pkg;
    // Stack geometry
    localparam int DEPTH = 16;
    localparam int PC_W = 15;
    localparam int IDX_W = 4;
    localparam int PTR_W = 5;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int TOP_OF_STACK_HIGH_W = 7;

    // Pointer values
    localparam logic [4:0] PTR_RESET = 5'h1f;
    localparam logic [4:0] PTR_FULL = 5'h0f;
    localparam logic [4:0] PTR_EMPTY = 5'h1f;
    localparam logic [4:0] PTR_UNF_WRAP = 5'h0e;
    localparam logic [4:0] PTR_OVF_WRAP = 5'h00;

    // Register offsets
    localparam logic [7:0] OFF_FLAGS = 8'h98;
    localparam logic [7:0] OFF_PTR = 8'ha0;
    localparam logic [7:0] OFF_TOP_OF_STACK_LOW = 8'ha4;
    localparam logic [7:0] OFF_TOP_OF_STACK_HIGH = 8'ha8;
    localparam logic [7:0] OFF_CFG = 8'hac;
    localparam logic [7:0] OFF_IRQ_STS = 8'hb0;
    localparam logic [7:0] OFF_IRQ_MASK = 8'hb4;

    // Field positions
    localparam int FLAG_OVF_BIT = 7;
    localparam int FLAG_UNF_BIT = 6;
    localparam int CFG_FRE_BIT = 0;
    localparam int EVT_OVF_BIT = 0;
    localparam int EVT_UNF_BIT = 1;
    localparam int EVT_W = 2;

    // Values after reset
    localparam logic CFG_FRE_RESET = 1'b0;
    localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
    localparam logic [7:0] RDATA_IDLE = 8'h00;
endpackage
`default_nettype wire

//--- logic/crhs_stack_mem.sv
`default_nettype none
// Dedicated stack storage, one write and one read port
module crhs_stack_mem (
    input wire logic core_clk,
    input wire logic wr_en,
    input wire logic [3:0] wr_idx,
    input wire logic [14:0] wr_data,
    input wire logic [3:0] rd_idx,
    output logic [14:0] rd_data
);
    logic [14:0] entry_q [crhs_pkg::DEPTH];

    // Storage has no reset; contents are undefined until written
    always_ff @(posedge core_clk) begin
        if (wr_en) begin
            entry_q[wr_idx] <= wr_data;
        end
    end

    // Combinational read so a pop sees the entry at once
    assign rd_data = entry_q[rd_idx];
endmodule
`default_nettype wire

//--- logic/crhs_stack.sv
`default_nettype none
module crhs_stack (
    core_clk,
    rst_b,
    call_push,
    call_via_working_reg,
    irq_vector_push,
    ret_pop,
    return_with_literal,
    return_from_interrupt,
    pc_in,
    pop_pc,
    pop_valid,
    fault_reset_req,
    reg_addr,
    reg_wdata,
    reg_wr,
    reg_rd,
    reg_rdata,
    irq
);
    input wire logic core_clk;
    input wire logic rst_b;
    input wire logic call_push;
    input wire logic call_via_working_reg;
    input wire logic irq_vector_push;
    input wire logic ret_pop;
    input wire logic return_with_literal;
    input wire logic return_from_interrupt;
    input wire logic [14:0] pc_in;
    output logic [14:0] pop_pc;
    output logic pop_valid;
    output logic fault_reset_req;
    input wire logic [7:0] reg_addr;
    input wire logic [7:0] reg_wdata;
    input wire logic reg_wr;
    input wire logic reg_rd;
    output logic [7:0] reg_rdata;
    output logic irq;

    logic rst_meta_q;
    logic rst_n;
    logic [4:0] stack_pointer_reg_q;
    logic [4:0] ptr_d;
    logic stack_overflow_flag_q;
    logic stack_underflow_flag_q;
    logic stack_fault_reset_enable_q;
    logic [1:0] irq_sts_q;
    logic [1:0] irq_mask_q;
    logic [14:0] pop_pc_q;
    logic pop_valid_q;
    logic fault_reset_q;
    logic [7:0] rdata_q;
    logic push_evt;
    logic pop_evt;
    logic ovf_evt;
    logic unf_evt;
    logic [1:0] evt;
    logic mem_we;
    logic [3:0] mem_widx;
    logic [14:0] mem_wdata;
    logic [14:0] tos;
    logic wr_flags;
    logic wr_ptr;
    logic wr_top_of_stack_low;
    logic wr_top_of_stack_high;
    logic wr_cfg;
    logic wr_sts;
    logic wr_mask;

    // Address match, shared by every register write strobe
    function automatic logic hit(input logic stb, input logic [7:0] a,
                                 input logic [7:0] off);
        hit = stb && (a == off);
    endfunction

    // Reset release through two flops; assertion is still immediate
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n <= rst_meta_q;
        end
    end

    // Sequencer requests; push wins if both arrive together
    assign push_evt = call_push | call_via_working_reg | irq_vector_push;
    assign pop_evt = (ret_pop | return_with_literal | return_from_interrupt)
                     & ~push_evt;
    assign ovf_evt = push_evt && (stack_pointer_reg_q == crhs_pkg::PTR_FULL);
    assign unf_evt = pop_evt && (stack_pointer_reg_q == crhs_pkg::PTR_EMPTY);
    assign evt = {unf_evt, ovf_evt};

    // Register write decode
    assign wr_flags = hit(reg_wr, reg_addr, crhs_pkg::OFF_FLAGS);
    assign wr_ptr = hit(reg_wr, reg_addr, crhs_pkg::OFF_PTR);
    assign wr_top_of_stack_low = hit(reg_wr, reg_addr, crhs_pkg::OFF_TOP_OF_STACK_LOW);
    assign wr_top_of_stack_high = hit(reg_wr, reg_addr, crhs_pkg::OFF_TOP_OF_STACK_HIGH);
    assign wr_cfg = hit(reg_wr, reg_addr, crhs_pkg::OFF_CFG);
    assign wr_sts = hit(reg_wr, reg_addr, crhs_pkg::OFF_IRQ_STS);
    assign wr_mask = hit(reg_wr, reg_addr, crhs_pkg::OFF_IRQ_MASK);

    // Next pointer; wrap keeps the stack usable as a ring
    always_comb begin
        ptr_d = stack_pointer_reg_q;
        if (push_evt) begin
            if (ovf_evt) begin
                ptr_d = crhs_pkg::PTR_OVF_WRAP;
            end else begin
                ptr_d = stack_pointer_reg_q + 5'h01;
            end
        end else if (pop_evt) begin
            if (unf_evt) begin
                ptr_d = crhs_pkg::PTR_UNF_WRAP;
            end else begin
                ptr_d = stack_pointer_reg_q - 5'h01;
            end
        end else if (wr_ptr) begin
            ptr_d = reg_wdata[4:0];
        end
    end

    // Five-bit pointer; hardware motion beats a software write
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stack_pointer_reg_q <= crhs_pkg::PTR_RESET;
        end else begin
            stack_pointer_reg_q <= ptr_d;
        end
    end

    // Storage write: pushes go to the slot after the pointer
    always_comb begin
        mem_we = 1'b0;
        mem_widx = stack_pointer_reg_q[3:0];
        mem_wdata = tos;
        if (push_evt) begin
            mem_we = 1'b1;
            mem_widx = ptr_d[3:0];
            mem_wdata = pc_in;
        end else if (!pop_evt && !wr_ptr && wr_top_of_stack_low) begin
            mem_we = 1'b1;
            mem_wdata = {tos[14:8], reg_wdata};
        end else if (!pop_evt && !wr_ptr && wr_top_of_stack_high) begin
            mem_we = 1'b1;
            mem_wdata = {reg_wdata[6:0], tos[7:0]};
        end
    end

    // Private array, reached only via the top-of-stack window
    crhs_stack_mem u_mem (
        .core_clk(core_clk),
        .wr_en(mem_we),
        .wr_idx(mem_widx),
        .wr_data(mem_wdata),
        .rd_idx(stack_pointer_reg_q[3:0]),
        .rd_data(tos)
    );

    // Popped PC handed back a cycle later; the high latch is not here
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pop_pc_q <= '0;
            pop_valid_q <= 1'b0;
        end else begin
            pop_valid_q <= pop_evt;
            if (pop_evt) begin
                pop_pc_q <= tos;
            end
        end
    end

    // Fault flags; hardware set wins over a software clear
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stack_overflow_flag_q <= 1'b0;
            stack_underflow_flag_q <= 1'b0;
        end else begin
            if (ovf_evt) begin
                stack_overflow_flag_q <= 1'b1;
            end else if (wr_flags) begin
                stack_overflow_flag_q <= reg_wdata[crhs_pkg::FLAG_OVF_BIT];
            end
            if (unf_evt) begin
                stack_underflow_flag_q <= 1'b1;
            end else if (wr_flags) begin
                stack_underflow_flag_q <= reg_wdata[crhs_pkg::FLAG_UNF_BIT];
            end
        end
    end

    // Mode bit, held in a register of its own
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stack_fault_reset_enable_q <= crhs_pkg::CFG_FRE_RESET;
        end else if (wr_cfg) begin
            stack_fault_reset_enable_q <= reg_wdata[crhs_pkg::CFG_FRE_BIT];
        end
    end

    // Reset request, one pulse beside the flag it follows
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_reset_q <= 1'b0;
        end else begin
            fault_reset_q <= (|evt) & stack_fault_reset_enable_q;
        end
    end

    // Interrupt status: sticky, write one to clear, set wins
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_sts_q <= '0;
        end else if (wr_sts) begin
            irq_sts_q <= (irq_sts_q & ~reg_wdata[1:0]) | evt;
        end else begin
            irq_sts_q <= irq_sts_q | evt;
        end
    end

    // Interrupt mask, same layout as status
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_mask_q <= crhs_pkg::IRQ_MASK_RESET;
        end else if (wr_mask) begin
            irq_mask_q <= reg_wdata[1:0];
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= crhs_pkg::RDATA_IDLE;
        end else begin
            rdata_q <= crhs_pkg::RDATA_IDLE;
            if (reg_rd) begin
                unique case (reg_addr)
                    crhs_pkg::OFF_FLAGS:
                        rdata_q <= {stack_overflow_flag_q,
                                    stack_underflow_flag_q, 6'h00};
                    crhs_pkg::OFF_PTR:
                        rdata_q <= {3'h0, stack_pointer_reg_q};
                    crhs_pkg::OFF_TOP_OF_STACK_LOW:
                        rdata_q <= tos[7:0];
                    crhs_pkg::OFF_TOP_OF_STACK_HIGH:
                        rdata_q <= {1'b0, tos[14:8]};
                    crhs_pkg::OFF_CFG:
                        rdata_q <= {7'h00, stack_fault_reset_enable_q};
                    crhs_pkg::OFF_IRQ_STS:
                        rdata_q <= {6'h00, irq_sts_q};
                    crhs_pkg::OFF_IRQ_MASK:
                        rdata_q <= {6'h00, irq_mask_q};
                    default:
                        rdata_q <= crhs_pkg::RDATA_IDLE;
                endcase
            end
        end
    end

    // Outputs
    assign pop_pc = pop_pc_q;
    assign pop_valid = pop_valid_q;
    assign fault_reset_req = fault_reset_q;
    assign reg_rdata = rdata_q;
    assign irq = |(irq_sts_q & irq_mask_q);

    // Checks
    chk_push_increments: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (push_evt && stack_pointer_reg_q != crhs_pkg::PTR_FULL)
        |=> stack_pointer_reg_q == $past(stack_pointer_reg_q) + 5'h01)
        else $error("push did not advance the pointer by one");

    chk_push_stores_pc: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        push_evt |=> tos == $past(pc_in))
        else $error("pushed PC not on top of stack");

    chk_pop_returns_top: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        pop_evt |=> pop_valid && pop_pc == $past(tos))
        else $error("pop did not return the top entry");

    chk_pop_decrements: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (pop_evt && stack_pointer_reg_q != crhs_pkg::PTR_EMPTY)
        |=> stack_pointer_reg_q == $past(stack_pointer_reg_q) - 5'h01)
        else $error("pop did not lower the pointer by one");

    chk_ovf_wraps: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        ovf_evt |=> stack_pointer_reg_q == crhs_pkg::PTR_OVF_WRAP
                    && stack_overflow_flag_q)
        else $error("overflow did not wrap to the first entry");

    chk_unf_flag_set: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        unf_evt |=> stack_underflow_flag_q && irq_sts_q[1])
        else $error("underflow flag not set");

    chk_fault_reset_on: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        ((|evt) && stack_fault_reset_enable_q) |=> fault_reset_req ##1
        !fault_reset_req || $past(|evt))
        else $error("fault reset not requested");

    chk_ring_no_reset: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !stack_fault_reset_enable_q ##1 !$past(stack_fault_reset_enable_q)
        |-> !fault_reset_req)
        else $error("reset requested in circular mode");

    chk_rdata_one_cycle: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !reg_rd |=> reg_rdata == crhs_pkg::RDATA_IDLE)
        else $error("read data outside its cycle");

    cov_overflow: cover property (
        @(posedge core_clk) disable iff (!rst_n) ovf_evt);
    cov_underflow: cover property (
        @(posedge core_clk) disable iff (!rst_n) unf_evt);
    cov_wrap_then_pop: cover property (
        @(posedge core_clk) disable iff (!rst_n) ovf_evt ##[1:20] pop_evt);
    cov_sw_tos_write: cover property (
        @(posedge core_clk) disable iff (!rst_n) wr_top_of_stack_high ##1 reg_rd);
endmodule
`default_nettype wire

//--- dv/crhs_seq_model.sv
`default_nettype none
// Sequencer stand-in: turns a bench opcode into one-cycle push/pop strobes
module crhs_seq_model (
    input wire logic core_clk,
    input wire logic [2:0] op,
    input wire logic [14:0] op_pc,
    output logic call_push,
    output logic call_via_working_reg,
    output logic irq_vector_push,
    output logic ret_pop,
    output logic return_with_literal,
    output logic return_from_interrupt,
    output logic [14:0] pc_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [14:0] noise_q = 15'h2a5a;
    logic pushing;

    // Churning pattern so a stale PC is never mistaken for a pushed one
    // Plain always: the start value comes from the declaration
    always @(posedge core_clk) begin
        noise_q <= ~noise_q ^ 15'h0001;
    end

    // Three push sources and three pop sources, one strobe per opcode
    assign call_push = (op == 3'h1);
    assign call_via_working_reg = (op == 3'h2);
    assign irq_vector_push = (op == 3'h3);
    assign ret_pop = (op == 3'h4);
    assign return_with_literal = (op == 3'h5);
    assign return_from_interrupt = (op == 3'h6);
    assign pushing = (op >= 3'h1) && (op <= 3'h3);
    assign pc_in = pushing ? op_pc : noise_q;
endmodule
`default_nettype wire

//--- dv/tb.sv
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [2:0] op = 3'h0;
    logic [14:0] op_pc = 15'h0000;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic cp, cw, iv, rp, rl, ri, pop_valid, fault_reset_req, irq;
    logic [14:0] pc_in, pop_pc;
    logic [7:0] reg_rdata;
    int bad_count = 0;
    int checks = 0;
    int frr_seen = 0;

    // Free-running core clock, 100 ns period
    always #50 core_clk = ~core_clk;

    crhs_seq_model seq (.core_clk(core_clk), .op(op), .op_pc(op_pc),
        .call_push(cp), .call_via_working_reg(cw), .irq_vector_push(iv),
        .ret_pop(rp), .return_with_literal(rl),
        .return_from_interrupt(ri), .pc_in(pc_in));

    crhs_stack uut (.core_clk(core_clk), .rst_b(rst_b), .call_push(cp),
        .call_via_working_reg(cw), .irq_vector_push(iv), .ret_pop(rp),
        .return_with_literal(rl), .return_from_interrupt(ri),
        .pc_in(pc_in), .pop_pc(pop_pc), .pop_valid(pop_valid),
        .fault_reset_req(fault_reset_req), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq(irq));

    // Count reset requests; a stray one in circular mode is a fault
    always @(posedge core_clk) begin
        if (fault_reset_req === 1'b1) frr_seen++;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] m,
                      input logic [7:0] exp);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk({8'h00, reg_rdata & m}, {8'h00, exp});
    endtask

    // One sequencer request, held for exactly one edge
    task automatic op_do(input logic [2:0] k, input logic [14:0] pc);
        @(posedge core_clk);
        op <= k;
        op_pc <= pc;
        @(posedge core_clk);
        op <= 3'h0;
        #1;
    endtask

    task automatic tos_chk(input logic [14:0] v);
        rd(crhs_pkg::OFF_TOP_OF_STACK_LOW, 8'hff, v[7:0]);
        rd(crhs_pkg::OFF_TOP_OF_STACK_HIGH, 8'h7f, {1'b0, v[14:8]});
    endtask

    task automatic t_reset;
        rd(crhs_pkg::OFF_PTR, 8'hff, 8'h1f);
        rd(crhs_pkg::OFF_CFG, 8'hff, 8'h00);
        rd(crhs_pkg::OFF_IRQ_MASK, 8'hff, 8'h00);
        rd(crhs_pkg::OFF_FLAGS, 8'hff, 8'h00);
        rd(crhs_pkg::OFF_IRQ_STS, 8'hff, 8'h00);
        chk({15'h0, irq}, 16'h0000);
    endtask

    // All three push kinds, then all three pop kinds in reverse
    task automatic t_push_pop;
        for (int k = 1; k <= 3; k++) begin
            op_do(3'(k), 15'h1000 + 15'(k));
            rd(crhs_pkg::OFF_PTR, 8'hff, 8'(k - 1));
            tos_chk(15'h1000 + 15'(k));
        end
        for (int k = 4; k <= 6; k++) begin
            op_do(3'(k), 15'h0000);
            chk({15'h0, pop_valid}, 16'h0001);
            chk({1'b0, pop_pc}, 16'h1000 + 16'(7 - k));
            rd(crhs_pkg::OFF_PTR, 8'hff, {3'h0, 5'(5 - k)});
        end
        // Pop strobe back is a single-cycle pulse
        chk({15'h0, pop_valid}, 16'h0000);
    endtask

    // Seventeen pushes with fault reset off: wrap over the oldest entry
    task automatic t_circular;
        frr_seen = 0;
        for (int i = 0; i < 17; i++) begin
            op_do(3'h1, 15'h2000 + 15'(i));
            if (i == 15) rd(crhs_pkg::OFF_PTR, 8'hff, 8'h0f);
        end
        rd(crhs_pkg::OFF_PTR, 8'hff, 8'h00);
        rd(crhs_pkg::OFF_FLAGS, 8'hc0, 8'h80);
        tos_chk(15'h2010);
        wr(crhs_pkg::OFF_PTR, 8'h01);
        tos_chk(15'h2001);
        chk(16'(frr_seen), 16'h0000);
        wr(crhs_pkg::OFF_IRQ_MASK, 8'h02);
        chk({15'h0, irq}, 16'h0000);
        wr(crhs_pkg::OFF_IRQ_MASK, 8'h03);
        chk({15'h0, irq}, 16'h0001);
        wr(crhs_pkg::OFF_IRQ_STS, 8'h01);
        chk({15'h0, irq}, 16'h0000);
    endtask

    // Pop from an empty stack returns the top slot and flags underflow
    task automatic t_underflow;
        wr(crhs_pkg::OFF_FLAGS, 8'h00);
        wr(crhs_pkg::OFF_PTR, 8'h1f);
        op_do(3'h4, 15'h0000);
        chk({1'b0, pop_pc}, 16'h200f);
        rd(crhs_pkg::OFF_PTR, 8'hff, 8'h0e);
        rd(crhs_pkg::OFF_FLAGS, 8'hc0, 8'h40);
        chk({15'h0, irq}, 16'h0001);
        rd(crhs_pkg::OFF_IRQ_STS, 8'h03, 8'h02);
        wr(crhs_pkg::OFF_IRQ_STS, 8'h02);
        chk({15'h0, irq}, 16'h0000);
    endtask

    // Fault reset enabled: both faults ask for a reset, once each
    task automatic t_fault;
        wr(crhs_pkg::OFF_CFG, 8'h01);
        wr(crhs_pkg::OFF_FLAGS, 8'h00);
        wr(crhs_pkg::OFF_PTR, 8'h0f);
        frr_seen = 0;
        op_do(3'h2, 15'h0abc);
        chk({15'h0, fault_reset_req}, 16'h0001);
        rd(crhs_pkg::OFF_FLAGS, 8'hc0, 8'h80);
        wr(crhs_pkg::OFF_PTR, 8'h1f);
        op_do(3'h6, 15'h0000);
        chk({15'h0, fault_reset_req}, 16'h0001);
        // Counter samples the pulse one edge later; let that edge pass
        @(posedge core_clk);
        #1 chk(16'(frr_seen), 16'h0002);
        wr(crhs_pkg::OFF_CFG, 8'h00);
    endtask

    // Software places an entry, then a return hands it back
    task automatic t_sw_tos;
        wr(crhs_pkg::OFF_PTR, 8'h05);
        wr(crhs_pkg::OFF_TOP_OF_STACK_LOW, 8'h34);
        wr(crhs_pkg::OFF_TOP_OF_STACK_HIGH, 8'h12);
        tos_chk(15'h1234);
        op_do(3'h5, 15'h0000);
        chk({1'b0, pop_pc}, 16'h1234);
        rd(crhs_pkg::OFF_PTR, 8'hff, 8'h04);
        wr(8'h9c, 8'hff);
        rd(8'h9c, 8'hff, 8'h00);
    endtask

    task automatic tally_and_finish;
        $display("Counts: checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Main sequence: reset held three cycles, then the scenarios
    initial begin
        repeat (3) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge core_clk);
        t_reset();
        t_push_pop();
        t_circular();
        t_underflow();
        t_fault();
        t_sw_tos();
        tally_and_finish();
    end

    // Watchdog, far beyond the roughly 160 cycles the scenarios need
    initial begin
        #2000000;
        bad_count++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
